// ---- src/ofs_pkg.sv ----
// Purpose: Constants and types shared by the output function selector.
// Assumes: One system clock; feature codes are chosen locally.
// Notes:   Code zero selects nothing and keeps an output off.

package ofs_pkg;

  // Number of configurable outputs and width of a feature-select code.
  localparam int unsigned NUM_OUT  = 8;
  localparam int unsigned SEL_W    = 6;
  localparam int unsigned NUM_FEAT = 64;

  // Value of every output register after reset.
  localparam logic [NUM_OUT-1:0] OUT_RST = 8'h00;
  localparam logic               LATCH_RST = 1'b0;

  // Feature-select codes, one per selectable condition.
  localparam logic [SEL_W-1:0] SEL_NONE         = 6'h00;
  localparam logic [SEL_W-1:0] SEL_HI_TEMP_FAIL = 6'h01;
  localparam logic [SEL_W-1:0] SEL_HI_TEMP_WARN = 6'h02;
  localparam logic [SEL_W-1:0] SEL_LO_OIL_FAIL  = 6'h03;
  localparam logic [SEL_W-1:0] SEL_LO_OIL_WARN  = 6'h04;
  localparam logic [SEL_W-1:0] SEL_UNDER_SPD_F  = 6'h05;
  localparam logic [SEL_W-1:0] SEL_UNDER_SPD_W  = 6'h06;
  localparam logic [SEL_W-1:0] SEL_OVER_SPD_F   = 6'h07;
  localparam logic [SEL_W-1:0] SEL_OVER_SPD_W   = 6'h08;
  localparam logic [SEL_W-1:0] SEL_LO_FUEL_FAIL = 6'h09;
  localparam logic [SEL_W-1:0] SEL_LO_FUEL_WARN = 6'h0A;
  localparam logic [SEL_W-1:0] SEL_BATT_FAIL    = 6'h0B;
  localparam logic [SEL_W-1:0] SEL_BATT_WARN    = 6'h0C;
  localparam logic [SEL_W-1:0] SEL_LO_COOLANT   = 6'h0D;
  localparam logic [SEL_W-1:0] SEL_NOT_AUTO     = 6'h0E;
  localparam logic [SEL_W-1:0] SEL_GEN_FAIL     = 6'h0F;
  localparam logic [SEL_W-1:0] SEL_CRANK_REST   = 6'h10;
  localparam logic [SEL_W-1:0] SEL_ENG_RUN      = 6'h11;
  localparam logic [SEL_W-1:0] SEL_ENG_CRANK    = 6'h12;
  localparam logic [SEL_W-1:0] SEL_AC_UV_WARN   = 6'h13;
  localparam logic [SEL_W-1:0] SEL_AC_OV_WARN   = 6'h14;
  localparam logic [SEL_W-1:0] SEL_AC_OC_WARN   = 6'h15;
  localparam logic [SEL_W-1:0] SEL_BASIN_WARN   = 6'h16;
  localparam logic [SEL_W-1:0] SEL_LO_TEMP_WARN = 6'h17;
  localparam logic [SEL_W-1:0] SEL_BACKLIGHT    = 6'h18;
  localparam logic [SEL_W-1:0] SEL_AUX_WARN     = 6'h19;
  localparam logic [SEL_W-1:0] SEL_MAINT        = 6'h1A;
  localparam logic [SEL_W-1:0] SEL_SYS_READY    = 6'h1B;
  localparam logic [SEL_W-1:0] SEL_COMMON_1     = 6'h1C;
  localparam logic [SEL_W-1:0] SEL_COMMON_2     = 6'h1D;
  localparam logic [SEL_W-1:0] SEL_DUMMY_LOAD   = 6'h1E;
  localparam logic [SEL_W-1:0] SEL_HI_FUEL      = 6'h1F;
  localparam logic [SEL_W-1:0] SEL_CUR_LATCH    = 6'h20;
  localparam logic [SEL_W-1:0] SEL_CFG_WARN_1   = 6'h21;
  localparam logic [SEL_W-1:0] SEL_CFG_WARN_2   = 6'h22;
  localparam logic [SEL_W-1:0] SEL_CFG_FAIL_1   = 6'h23;
  localparam logic [SEL_W-1:0] SEL_CFG_FAIL_2   = 6'h24;
  localparam logic [SEL_W-1:0] SEL_WARM_UP      = 6'h25;

endpackage

// ---- src/ofs_output_function_selector.sv ----
// Purpose: Routes one controller condition to each configurable digital output.
// Assumes: Condition inputs are synchronous to clock_i; select codes are static.
// Notes:   Outputs are registered, so each follows its condition one edge later.
// What this block does
// - High temperature failure and warning selections follow their conditions.
// - Low oil pressure failure and warning selections follow their conditions.
// - Under-speed and over-speed failure and warning selections follow conditions.
// - Low fuel failure and warning selections follow their conditions.
// - Battery failure or warning is low OR high battery condition.
// - Low coolant failure selection follows the coolant failure input.
// - Not-in-auto selection is on whenever state is not automatic.
// - General failure selection is the OR of all failures.
// - Crank rest selection is on only during the rest after a crank.
// - Engine running selection is on while the run state lasts.
// - Engine cranking selection mirrors the crank output exactly.
// - AC under-voltage, over-voltage, over-current warning selections follow conditions.
// - Fuel-in-basin and low temperature warning selections follow conditions.
// - Backlight selection is off while in sleep, on otherwise.
// - Auxiliary warning selection follows the auxiliary warning input.
// - Maintenance selection is on while service is due.
// - System ready is automatic state with no non-excluded warning.
// - Two common fault selections follow their fault groupings.
// - Dummy load selection hands the output to the dummy load function.
// - High fuel level selection follows its digital input.
// - Current latch sets on enabled high current warning; only user clears.
// - Four configurable warning and failure echoes follow their inputs.
// - Each feature may be assigned to at most one output.
// - Warm-up output off during warm-up and outside run mode.

`timescale 1ns/10ps
`default_nettype none

module ofs_output_function_selector (
  input  wire logic                                  clock_i,
  input  wire logic                                  arst_n_i,
  input  wire logic [ofs_pkg::NUM_OUT*ofs_pkg::SEL_W-1:0] out_sel_i,
  input  wire logic                                  hi_temp_fail_i,
  input  wire logic                                  hi_temp_warn_i,
  input  wire logic                                  lo_oil_fail_i,
  input  wire logic                                  lo_oil_warn_i,
  input  wire logic                                  under_spd_fail_i,
  input  wire logic                                  under_spd_warn_i,
  input  wire logic                                  over_spd_fail_i,
  input  wire logic                                  over_spd_warn_i,
  input  wire logic                                  lo_fuel_fail_i,
  input  wire logic                                  lo_fuel_warn_i,
  input  wire logic                                  lo_batt_fail_i,
  input  wire logic                                  hi_batt_fail_i,
  input  wire logic                                  lo_batt_warn_i,
  input  wire logic                                  hi_batt_warn_i,
  input  wire logic                                  lo_coolant_fail_i,
  input  wire logic                                  state_auto_i,
  input  wire logic                                  other_fail_i,
  input  wire logic                                  other_warn_i,
  input  wire logic                                  state_crank_rest_i,
  input  wire logic                                  state_run_i,
  input  wire logic                                  crank_out_i,
  input  wire logic                                  ac_uv_warn_i,
  input  wire logic                                  ac_ov_warn_i,
  input  wire logic                                  ac_oc_warn_i,
  input  wire logic                                  basin_warn_i,
  input  wire logic                                  lo_temp_warn_i,
  input  wire logic                                  sleep_i,
  input  wire logic                                  aux_warn_in_i,
  input  wire logic                                  maint_due_i,
  input  wire logic                                  common_fault_1_i,
  input  wire logic                                  common_fault_2_i,
  input  wire logic                                  dummy_load_ctl_i,
  input  wire logic                                  hi_fuel_in_i,
  input  wire logic                                  cur_warn_latch_en_i,
  input  wire logic                                  hi_cur_warn_i,
  input  wire logic                                  cur_latch_clr_i,
  input  wire logic                                  cfg_warn_1_in_i,
  input  wire logic                                  cfg_warn_2_in_i,
  input  wire logic                                  cfg_fail_1_in_i,
  input  wire logic                                  cfg_fail_2_in_i,
  input  wire logic                                  warm_up_done_i,
  output logic      [ofs_pkg::NUM_OUT-1:0]           out_o,
  output logic      [ofs_pkg::NUM_OUT-1:0]           sel_conflict_o,
  output logic                                       cur_latch_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Condition vector, indexed by feature-select code.

  logic [ofs_pkg::NUM_FEAT-1:0] cond;
  logic                         any_fail;
  logic                         ready_warn;
  logic                         cur_latch_r;
  logic                         cur_latch_nxt;

  // Every failure feeds the general failure term.
  assign any_fail = hi_temp_fail_i | lo_oil_fail_i | under_spd_fail_i
                  | over_spd_fail_i | lo_fuel_fail_i | lo_batt_fail_i
                  | hi_batt_fail_i | lo_coolant_fail_i | cfg_fail_1_in_i
                  | cfg_fail_2_in_i | other_fail_i;

  // Warnings that spoil readiness; battery voltage warnings are left out.
  assign ready_warn = hi_temp_warn_i | lo_oil_warn_i | under_spd_warn_i
                    | over_spd_warn_i | lo_fuel_warn_i | ac_uv_warn_i
                    | ac_ov_warn_i | ac_oc_warn_i | basin_warn_i
                    | lo_temp_warn_i | aux_warn_in_i | hi_fuel_in_i
                    | cfg_warn_1_in_i | cfg_warn_2_in_i | other_warn_i
                    | hi_cur_warn_i;

  // Map each selectable condition to its code; unused codes stay zero.
  always_comb begin
    cond = '0;
    cond[ofs_pkg::SEL_HI_TEMP_FAIL] = hi_temp_fail_i;
    cond[ofs_pkg::SEL_HI_TEMP_WARN] = hi_temp_warn_i;
    cond[ofs_pkg::SEL_LO_OIL_FAIL]  = lo_oil_fail_i;
    cond[ofs_pkg::SEL_LO_OIL_WARN]  = lo_oil_warn_i;
    cond[ofs_pkg::SEL_UNDER_SPD_F]  = under_spd_fail_i;
    cond[ofs_pkg::SEL_UNDER_SPD_W]  = under_spd_warn_i;
    cond[ofs_pkg::SEL_OVER_SPD_F]   = over_spd_fail_i;
    cond[ofs_pkg::SEL_OVER_SPD_W]   = over_spd_warn_i;
    cond[ofs_pkg::SEL_LO_FUEL_FAIL] = lo_fuel_fail_i;
    cond[ofs_pkg::SEL_LO_FUEL_WARN] = lo_fuel_warn_i;
    cond[ofs_pkg::SEL_BATT_FAIL]    = lo_batt_fail_i | hi_batt_fail_i;
    cond[ofs_pkg::SEL_BATT_WARN]    = lo_batt_warn_i | hi_batt_warn_i;
    cond[ofs_pkg::SEL_LO_COOLANT]   = lo_coolant_fail_i;
    cond[ofs_pkg::SEL_NOT_AUTO]     = ~state_auto_i;
    cond[ofs_pkg::SEL_GEN_FAIL]     = any_fail;
    cond[ofs_pkg::SEL_CRANK_REST]   = state_crank_rest_i;
    cond[ofs_pkg::SEL_ENG_RUN]      = state_run_i;
    cond[ofs_pkg::SEL_ENG_CRANK]    = crank_out_i;
    cond[ofs_pkg::SEL_AC_UV_WARN]   = ac_uv_warn_i;
    cond[ofs_pkg::SEL_AC_OV_WARN]   = ac_ov_warn_i;
    cond[ofs_pkg::SEL_AC_OC_WARN]   = ac_oc_warn_i;
    cond[ofs_pkg::SEL_BASIN_WARN]   = basin_warn_i;
    cond[ofs_pkg::SEL_LO_TEMP_WARN] = lo_temp_warn_i;
    cond[ofs_pkg::SEL_BACKLIGHT]    = ~sleep_i;
    cond[ofs_pkg::SEL_AUX_WARN]     = aux_warn_in_i;
    cond[ofs_pkg::SEL_MAINT]        = maint_due_i;
    cond[ofs_pkg::SEL_SYS_READY]    = state_auto_i & ~ready_warn;
    cond[ofs_pkg::SEL_COMMON_1]     = common_fault_1_i;
    cond[ofs_pkg::SEL_COMMON_2]     = common_fault_2_i;
    cond[ofs_pkg::SEL_DUMMY_LOAD]   = dummy_load_ctl_i;
    cond[ofs_pkg::SEL_HI_FUEL]      = hi_fuel_in_i;
    // Use the next latch value so the output turns on with the latch itself.
    cond[ofs_pkg::SEL_CUR_LATCH]    = cur_latch_nxt;
    cond[ofs_pkg::SEL_CFG_WARN_1]   = cfg_warn_1_in_i;
    cond[ofs_pkg::SEL_CFG_WARN_2]   = cfg_warn_2_in_i;
    cond[ofs_pkg::SEL_CFG_FAIL_1]   = cfg_fail_1_in_i;
    cond[ofs_pkg::SEL_CFG_FAIL_2]   = cfg_fail_2_in_i;
    cond[ofs_pkg::SEL_WARM_UP]      = state_run_i & warm_up_done_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Current warning latch.

  // A new warning wins over a user clear arriving in the same cycle.
  assign cur_latch_nxt = (cur_warn_latch_en_i & hi_cur_warn_i)
                       | (cur_latch_r & ~cur_latch_clr_i);

  // The latch holds until the user clears it.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur_latch_r <= ofs_pkg::LATCH_RST;
    end else begin
      cur_latch_r <= cur_latch_nxt;
    end
  end

  assign cur_latch_o = cur_latch_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-output selection and conflict check.

  genvar g;
  generate
    for (g = 0; g < ofs_pkg::NUM_OUT; g++) begin : g_out
      logic [ofs_pkg::SEL_W-1:0] sel;
      logic [ofs_pkg::NUM_OUT-1:0] dup;

      assign sel = out_sel_i[g*ofs_pkg::SEL_W +: ofs_pkg::SEL_W];

      // Flag a feature that another output also selects.
      always_comb begin
        dup = '0;
        for (int k = 0; k < ofs_pkg::NUM_OUT; k++) begin
          if (k != g && sel != ofs_pkg::SEL_NONE &&
              out_sel_i[k*ofs_pkg::SEL_W +: ofs_pkg::SEL_W] == sel) begin
            dup[k] = 1'b1;
          end
        end
      end

      // Outputs refresh every edge and clear under reset.
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          out_o[g]          <= ofs_pkg::OUT_RST[g];
          sel_conflict_o[g] <= ofs_pkg::OUT_RST[g];
        end else begin
          out_o[g]          <= cond[sel] & ~|dup;
          sel_conflict_o[g] <= |dup;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ---- verification/ofs_relay_bank.sv ----
// Purpose: Relay coils and lamps hung on the selector's output drives.
// Assumes: A coil pulls in its contact one clock after it is energised.
// Notes:   Contacts drop out at once when the board is reset.
`timescale 1ns/10ps
`default_nettype none
module ofs_relay_bank (
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  input  wire logic [7:0] drive_i,
  output var  logic [7:0] contact_o
);
  // Each contact follows its coil drive with one cycle of pull-in delay.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      contact_o <= 8'h00;
    end else begin
      contact_o <= drive_i;
    end
  end
endmodule
`default_nettype wire

// ---- verification/ofs_checker_asserts.sv ----
// Purpose: Port-level assertions for the output function selector.
// Assumes: Output 0 carries the feature whose routing is checked.
// Notes:   Outputs are registered, so each follows its cause one edge later.
`timescale 1ns/10ps
`default_nettype none
module ofs_checker (
  input wire logic clock_i, arst_n_i, hi_temp_fail_i, lo_batt_fail_i, hi_batt_fail_i,
  input wire logic state_auto_i, sleep_i, state_run_i, warm_up_done_i,
  input wire logic cur_warn_latch_en_i, hi_cur_warn_i, cur_latch_clr_i, cur_latch_o,
  input wire logic [ofs_pkg::NUM_OUT*ofs_pkg::SEL_W-1:0] out_sel_i,
  input wire logic [ofs_pkg::NUM_OUT-1:0]                out_o,
  input wire logic [ofs_pkg::NUM_OUT-1:0]                sel_conflict_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  logic [ofs_pkg::SEL_W-1:0] code0;
  logic                      ok0;
  // Output 0 shows its feature only when its code is not shared.
  assign code0 = out_sel_i[ofs_pkg::SEL_W-1:0];
  assign ok0   = ~sel_conflict_o[0];
  ////////////////////////////////////////
  a_hi_temp_route: assert property (code0 == ofs_pkg::SEL_HI_TEMP_FAIL
    |=> out_o[0] == ($past(hi_temp_fail_i) & ok0)) else $error("hi temp routing wrong");
  a_batt_fail_or: assert property (code0 == ofs_pkg::SEL_BATT_FAIL
    |=> out_o[0] == ($past(lo_batt_fail_i | hi_batt_fail_i) & ok0)) else $error("batt wrong");
  a_not_auto_drive: assert property (code0 == ofs_pkg::SEL_NOT_AUTO
    |=> out_o[0] == (!$past(state_auto_i) & ok0)) else $error("not auto wrong");
  a_backlight_inverted: assert property (code0 == ofs_pkg::SEL_BACKLIGHT
    |=> out_o[0] == (!$past(sleep_i) & ok0)) else $error("backlight wrong");
  a_warm_up_gate: assert property (code0 == ofs_pkg::SEL_WARM_UP
    |=> out_o[0] == ($past(state_run_i & warm_up_done_i) & ok0)) else $error("warm-up wrong");
  a_no_code_off: assert property (code0 == ofs_pkg::SEL_NONE |=> !out_o[0])
    else $error("unselected output driven");
  a_conflict_blanks: assert property (|(sel_conflict_o & out_o) == 1'b0)
    else $error("shared output driven");
  a_latch_sets: assert property (cur_warn_latch_en_i && hi_cur_warn_i |=> cur_latch_o)
    else $error("latch did not set");
  a_latch_holds: assert property (cur_latch_o && !cur_latch_clr_i |=> cur_latch_o)
    else $error("latch dropped without clear");
  a_latch_clears: assert property (cur_latch_o && cur_latch_clr_i
    && !(cur_warn_latch_en_i && hi_cur_warn_i) |=> !cur_latch_o) else $error("latch stuck");
  a_reset_quiet: assert property (disable iff (1'b0) !arst_n_i
    |-> out_o == '0 && sel_conflict_o == '0 && !cur_latch_o) else $error("reset not quiet");
  // Main scenarios seen at least once.
  cover property (cur_latch_o && !hi_cur_warn_i);
  cover property (|sel_conflict_o);
  cover property (code0 == ofs_pkg::SEL_SYS_READY ##1 out_o[0]);
endmodule
bind ofs_output_function_selector ofs_checker u_chk (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .hi_temp_fail_i(hi_temp_fail_i), .lo_batt_fail_i(lo_batt_fail_i), .sleep_i(sleep_i),
  .hi_batt_fail_i(hi_batt_fail_i), .state_auto_i(state_auto_i), .state_run_i(state_run_i),
  .warm_up_done_i(warm_up_done_i), .cur_warn_latch_en_i(cur_warn_latch_en_i),
  .hi_cur_warn_i(hi_cur_warn_i), .cur_latch_clr_i(cur_latch_clr_i), .out_sel_i(out_sel_i),
  .cur_latch_o(cur_latch_o), .out_o(out_o), .sel_conflict_o(sel_conflict_o));
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for the output function selector.
// Assumes: Conditions and codes change at the falling edge.
// Notes:   A reference model predicts every output one edge ahead.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic [ofs_pkg::NUM_OUT*ofs_pkg::SEL_W-1:0] sel = '0;
  logic        clock_i = 1'b0, arst_n_i = 1'b1, latch, el, ln;
  logic [7:0]  pe = 8'h00;
  logic [40:0] c = '0;
  logic [7:0]  out, cf, eo, ec, contact;
  logic [63:0] f, r;
  integer      seed = 29926;
  int          n_errors = 0, tests_run = 0;
  always #2 clock_i = ~clock_i;
  ofs_output_function_selector dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .out_sel_i(sel),
    .hi_temp_fail_i(c[0]), .hi_temp_warn_i(c[1]), .lo_oil_fail_i(c[2]), .lo_oil_warn_i(c[3]),
    .under_spd_fail_i(c[4]), .under_spd_warn_i(c[5]), .over_spd_fail_i(c[6]),
    .over_spd_warn_i(c[7]), .lo_fuel_fail_i(c[8]), .lo_fuel_warn_i(c[9]), .lo_batt_fail_i(c[10]),
    .hi_batt_fail_i(c[11]), .lo_batt_warn_i(c[12]), .hi_batt_warn_i(c[13]),
    .lo_coolant_fail_i(c[14]), .state_auto_i(c[15]), .other_fail_i(c[16]), .other_warn_i(c[17]),
    .state_crank_rest_i(c[18]), .state_run_i(c[19]), .crank_out_i(c[20]), .ac_uv_warn_i(c[21]),
    .ac_ov_warn_i(c[22]), .ac_oc_warn_i(c[23]), .basin_warn_i(c[24]), .lo_temp_warn_i(c[25]),
    .sleep_i(c[26]), .aux_warn_in_i(c[27]), .maint_due_i(c[28]), .common_fault_1_i(c[29]),
    .common_fault_2_i(c[30]), .dummy_load_ctl_i(c[31]), .hi_fuel_in_i(c[32]),
    .cur_warn_latch_en_i(c[33]), .hi_cur_warn_i(c[34]), .cur_latch_clr_i(c[35]),
    .cfg_warn_1_in_i(c[36]), .cfg_warn_2_in_i(c[37]), .cfg_fail_1_in_i(c[38]),
    .cfg_fail_2_in_i(c[39]), .warm_up_done_i(c[40]), .out_o(out), .sel_conflict_o(cf),
    .cur_latch_o(latch));
  ofs_relay_bank u_relays (.clock_i(clock_i), .arst_n_i(arst_n_i), .drive_i(out),
    .contact_o(contact));
  ////////////////////////////////////////
  // Condition seen by each feature code, indexed by the code itself.
  function automatic logic [63:0] feat(input logic [40:0] c, input logic l);
    logic w;
    w = |{c[1], c[3], c[5], c[7], c[9], c[17], c[25:21], c[27], c[32], c[34], c[37:36]};
    feat = '0;
    feat[10:1] = c[9:0];
    feat[14:11] = {~c[15], c[14], c[12] | c[13], c[10] | c[11]};
    feat[15] = |{c[0], c[2], c[4], c[6], c[8], c[10], c[11], c[14], c[16], c[38], c[39]};
    feat[23:16] = c[25:18];
    feat[27:24] = {c[15] & ~w, c[28:27], ~c[26]};
    feat[37:28] = {c[19] & c[40], c[39:36], l, c[32:29]};
  endfunction
  // An output is blanked when another output holds the same nonzero code.
  function automatic logic dup(input logic [47:0] s, input int g);
    dup = 1'b0;
    for (int h = 0; h < 8; h++) begin
      if (h != g && s[6*h+:6] == s[6*g+:6] && s[6*g+:6] != 6'h00) dup = 1'b1;
    end
  endfunction
  // Reference model, one edge of latency like the design.
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      eo <= 8'h00; ec <= 8'h00; el <= 1'b0;
    end else begin
      ln = (c[33] & c[34]) | (el & ~c[35]);
      f = feat(c, ln);
      el <= ln;
      for (int g = 0; g < 8; g++) begin
        eo[g] <= f[sel[6*g+:6]] & ~dup(sel, g);
        ec[g] <= dup(sel, g);
      end
    end
  end
  task automatic chk(input string what, input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t %s got=%h exp=%h", $time, what, got, exp);
      n_errors++;
    end
  endtask
  // Compare each cycle, then draw new conditions: dense or sparse.
  task automatic step(input int n, input logic dense);
    repeat (n) begin
      @(negedge clock_i);
      chk("out", {1'b0, out}, {1'b0, eo});
      chk("conflict", {1'b0, cf}, {1'b0, ec});
      chk("latch", {8'h00, latch}, {8'h00, el});
      chk("relay", {1'b0, contact}, {1'b0, pe});
      pe = eo;
      r = {$random(seed), $random(seed)};
      if (!dense) r = r & {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
      c = r[40:0];
      if (!dense) c[15] = ~c[16];
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence: code sweep, shared codes, random codes, mid-run reset.
  initial begin
    // A real falling edge on reset, so every flop leaves the unknown state.
    #1 arst_n_i = 1'b0;
    repeat (20) @(negedge clock_i);
    arst_n_i = 1'b1;
    for (int k = 0; k < 64; k++) begin
      sel = '0;
      sel[5:0] = 6'(k);
      step(6, 1'b0);
    end
    $display("test code sweep done");
    sel = {8{ofs_pkg::SEL_GEN_FAIL}};
    step(4, 1'b1);
    $display("test shared code done");
    for (int k = 0; k < 40; k++) begin
      for (int g = 0; g < 8; g++) sel[6*g+:6] = 6'($unsigned($random(seed)) % 38);
      step(20, k[0]);
    end
    $display("test random codes done");
    arst_n_i = 1'b0;
    pe = 8'h00;
    step(3, 1'b1);
    arst_n_i = 1'b1;
    step(10, 1'b1);
    $display("test mid-run reset done");
    print_verdict();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #40000;
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
